// ==== ptm_pkg.sv ====
// Package for the period timer: register map, field layout, reset values
package ptm_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;

  // Register byte addresses
  localparam logic [11:0] ADDR_COUNT   = 12'h000;
  localparam logic [11:0] ADDR_PERIOD  = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00c;
  localparam logic [11:0] ADDR_ENABLE  = 12'h010;
  localparam logic [11:0] ADDR_CLEAR   = 12'h014;
  localparam logic [11:0] ADDR_SLEEP   = 12'h018;

  // Control and status field positions
  localparam int CKPS_LSB = 0;
  localparam int RUN_BIT  = 2;
  localparam int OUTPS_LSB = 3;
  localparam int MATCH_BIT = 0;

  // Reset values and control write mask
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST  = 8'hff;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'h7f;

  // Instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  // Prescale select codes and terminal counts of the 6-bit prescaler
  localparam logic [1:0] CKPS_DIV1  = 2'h0;
  localparam logic [1:0] CKPS_DIV4  = 2'h1;
  localparam logic [1:0] CKPS_DIV16 = 2'h2;
  localparam logic [5:0] PRE_LAST1  = 6'h00;
  localparam logic [5:0] PRE_LAST4  = 6'h03;
  localparam logic [5:0] PRE_LAST16 = 6'h0f;
  localparam logic [5:0] PRE_LAST64 = 6'h3f;

  typedef struct packed {
    logic [3:0] outps;
    logic       run;
    logic [1:0] ckps;
  } ptm_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ptm_apb_req_t;
endpackage

// ==== ptm_timer.sv ====
// Period timer with prescaler, period compare, postscaler and match interrupt
`timescale 1ns/1ps
module ptm_timer #(
  // Widths fixed by the register layout
  parameter int unsigned COUNT_W = 8,
  parameter int unsigned POST_W  = 4
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  // APB slave
  input  wire ptm_pkg::ptm_apb_req_t apb_req_in,
  output logic [31:0]                prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Peripheral outputs
  output logic                       period_match_pulse_out,
  output logic                       irq_out
);
  import ptm_pkg::*;

  // Count and period share one byte lane, postscale select is four bits wide
  if (COUNT_W != 8) begin : g_count_w_check
    $error("COUNT_W must be 8");
  end
  if (POST_W != 4) begin : g_post_w_check
    $error("POST_W must be 4");
  end

  logic [7:0]  timer_count_q;
  logic [7:0]  period_value_q;
  ptm_ctrl_t   timer_control_q;
  logic        match_flag_q;
  logic        match_irq_enable_q;
  logic        sleep_q;
  logic [1:0]  instr_div_q;
  logic [5:0]  pre_cnt_q;
  logic [3:0]  post_cnt_q;
  logic        match_seen_q;
  logic        instr_tick;
  logic        pre_tick;
  logic        running;
  logic        is_match;
  logic        post_done;
  logic [5:0]  pre_last;
  logic        acc;
  logic        wr;
  logic        wr_count;
  logic        wr_ctrl;
  logic        wr_period;
  logic        wr_clear;
  logic        mapped;
  logic [31:0] rd_d;
  logic        scaler_clr;
  logic        flag_set;
  logic [7:0]  wdata_lo;

  // APB decode; the slave answers in the first access cycle
  assign acc       = apb_req_in.psel && apb_req_in.penable;
  assign wr        = acc && apb_req_in.pwrite;
  assign wr_count  = wr && apb_req_in.paddr == ADDR_COUNT;
  assign wr_period = wr && apb_req_in.paddr == ADDR_PERIOD;
  assign wr_ctrl   = wr && apb_req_in.paddr == ADDR_CONTROL;
  assign wr_clear  = wr && apb_req_in.paddr == ADDR_CLEAR;

  always_comb begin
    mapped = 1'b1;
    rd_d   = 32'h0000_0000;
    case (apb_req_in.paddr)
      ADDR_COUNT:   rd_d[7:0] = timer_count_q;
      ADDR_PERIOD:  rd_d[7:0] = period_value_q;
      ADDR_CONTROL: rd_d[7:0] = {1'b0, timer_control_q};
      ADDR_STATUS:  rd_d[MATCH_BIT] = match_flag_q;
      ADDR_ENABLE:  rd_d[MATCH_BIT] = match_irq_enable_q;
      ADDR_CLEAR:   rd_d = 32'h0000_0000;
      ADDR_SLEEP:   rd_d[0] = sleep_q;
      default:      mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      // One-cycle ready pulse: held low in setup, high in first access cycle
      pready_out  <= apb_req_in.psel && !apb_req_in.penable;
      prdata_out  <= rd_d;
      pslverr_out <= apb_req_in.psel && !apb_req_in.penable && !mapped;
    end
  end

  // Writes take effect on the edge where pready is sampled high
  logic wr_take;
  assign wr_take = wr && pready_out && !pslverr_out;
  assign scaler_clr = wr_take && (wr_count || wr_ctrl);
  assign wdata_lo   = apb_req_in.pwdata[7:0];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_control_q    <= ptm_ctrl_t'(CONTROL_RST[6:0]);
      period_value_q     <= PERIOD_RST;
      match_irq_enable_q <= 1'b0;
      sleep_q            <= 1'b0;
    end else if (wr_take) begin
      if (wr_ctrl) timer_control_q <= ptm_ctrl_t'(apb_req_in.pwdata[6:0] & CONTROL_MASK[6:0]);
      if (wr_period) period_value_q <= apb_req_in.pwdata[7:0];
      if (apb_req_in.paddr == ADDR_ENABLE) match_irq_enable_q <= apb_req_in.pwdata[MATCH_BIT];
      if (apb_req_in.paddr == ADDR_SLEEP) sleep_q <= apb_req_in.pwdata[0];
    end
  end

  // Timer runs only when on and the core is awake
  assign running = timer_control_q.run && !sleep_q;

  // Instruction clock enable: one pulse every four system clocks
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) instr_div_q <= 2'h0;
    else if (!sleep_q) instr_div_q <= instr_div_q + 2'h1;
  end
  assign instr_tick = !sleep_q && instr_div_q == INSTR_DIV_LAST;

  always_comb begin
    case (timer_control_q.ckps)
      CKPS_DIV1:  pre_last = PRE_LAST1;
      CKPS_DIV4:  pre_last = PRE_LAST4;
      CKPS_DIV16: pre_last = PRE_LAST16;
      default:    pre_last = PRE_LAST64;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) pre_cnt_q <= 6'h00;
    else if (scaler_clr) pre_cnt_q <= 6'h00;
    else if (running && instr_tick) begin
      pre_cnt_q <= (pre_cnt_q >= pre_last) ? 6'h00 : pre_cnt_q + 6'h01;
    end
  end
  // A scaler clear swallows a tick on the same edge, so a control write never moves the count
  assign pre_tick = running && instr_tick && pre_cnt_q >= pre_last && !scaler_clr;

  // Compare every cycle; a match is qualified by run so a stopped timer is silent
  assign is_match = running && timer_count_q == period_value_q;

  // Step the count on each prescaled tick; a tick that finds it equal to the period clears it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_count_q <= COUNT_RST;
    end else if (wr_take && wr_count) begin
      timer_count_q <= apb_req_in.pwdata[7:0];
    end else if (pre_tick) begin
      // Control writes never touch the count
      timer_count_q <= (timer_count_q == period_value_q) ? COUNT_RST : timer_count_q + 8'h01;
    end
  end

  // Match output: one pulse per period, on the tick that clears the count
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) period_match_pulse_out <= 1'b0;
    else period_match_pulse_out <= pre_tick && is_match;
  end

  assign post_done = post_cnt_q >= timer_control_q.outps;
  assign flag_set  = pre_tick && is_match && post_done;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) post_cnt_q <= 4'h0;
    else if (wr_take && (wr_count || wr_ctrl)) post_cnt_q <= 4'h0;
    else if (pre_tick && is_match) post_cnt_q <= post_done ? 4'h0 : post_cnt_q + 4'h1;
  end

  // Flag: set wins over a same-cycle software clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) match_flag_q <= 1'b0;
    else if (flag_set) match_flag_q <= 1'b1;
    else if (wr_take && wr_clear && apb_req_in.pwdata[MATCH_BIT]) match_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) irq_out <= 1'b0;
    else irq_out <= match_flag_q && match_irq_enable_q;
  end

  // Assertions
  a_sleep_holds_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (sleep_q && !(wr_take && wr_count)) |=> $stable(timer_count_q))
    else $error("count moved during sleep");
  a_stop_holds_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!timer_control_q.run && !(wr_take && wr_count)) |=> $stable(timer_count_q))
    else $error("count moved while stopped");
  a_match_clears_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pre_tick && is_match && !(wr_take && wr_count)) |=> timer_count_q == COUNT_RST)
    else $error("count not cleared after match");
  a_count_steps_one: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pre_tick && !is_match && !(wr_take && wr_count)) |=> timer_count_q == $past(timer_count_q) + 8'h01)
    else $error("count did not step by one");
  a_match_pulse_src: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    period_match_pulse_out |-> $past(timer_count_q) == $past(period_value_q))
    else $error("match pulse without equality");
  a_ctrl_keeps_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_ctrl) |=> timer_count_q == $past(timer_count_q) && post_cnt_q == 4'h0 && pre_cnt_q == 6'h00)
    else $error("control write disturbed count or scalers");
  a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (match_flag_q && !(wr_take && wr_clear)) |=> match_flag_q)
    else $error("flag dropped without clear");
  a_irq_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    irq_out |-> $past(match_flag_q) && $past(match_irq_enable_q))
    else $error("interrupt without enabled flag");
  a_instr_rate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than one in four");
  a_div1_postscale: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pre_tick && is_match && timer_control_q.outps == 4'h0 && !(wr_take && wr_clear)) |=> match_flag_q)
    else $error("1:1 postscale did not set flag");

  // Bus handshake and register access
  a_ready_after_setup: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (apb_req_in.psel && !apb_req_in.penable) |=> pready_out)
    else $error("ready missing after setup");

  a_ready_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");

  a_err_needs_ready: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
    else $error("error without ready or with data");

  a_count_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_count) |=> timer_count_q == $past(wdata_lo))
    else $error("count write lost");

  a_period_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_period) |=> period_value_q == $past(wdata_lo))
    else $error("period write lost");

  a_ctrl_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_ctrl) |=> {1'b0, timer_control_q} == ($past(wdata_lo) & CONTROL_MASK))
    else $error("control write lost");

  a_read_ctrl_top: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && apb_req_in.paddr == ADDR_CONTROL) |-> prdata_out[31:7] == 25'h0)
    else $error("control top bit read as one");

  a_read_count_byte: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && apb_req_in.paddr == ADDR_COUNT) |-> prdata_out[31:8] == 24'h0)
    else $error("count read upper bits set");

  a_status_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pready_out && apb_req_in.paddr == ADDR_STATUS) |-> prdata_out[31:1] == 31'h0)
    else $error("status read upper bits set");

  // Clock enables and scalers
  a_instr_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !sleep_q |=> instr_div_q == $past(instr_div_q) + 2'h1)
    else $error("instruction divider skipped");

  a_tick_on_instr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pre_tick |-> instr_tick)
    else $error("prescaled tick off the instruction tick");

  a_tick_needs_run: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pre_tick |-> running)
    else $error("tick while timer off");

  a_pre_in_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pre_cnt_q <= pre_last)
    else $error("prescaler past its terminal count");

  a_pre_steps: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (running && instr_tick && !scaler_clr && !pre_tick) |=> pre_cnt_q == $past(pre_cnt_q) + 6'h01)
    else $error("prescaler did not step");

  a_post_in_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    post_cnt_q <= timer_control_q.outps)
    else $error("postscaler past its ratio");

  a_post_steps: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pre_tick && is_match && !post_done) |=> post_cnt_q == $past(post_cnt_q) + 4'h1)
    else $error("postscaler did not count match");

  a_post_wraps: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    flag_set |=> post_cnt_q == 4'h0)
    else $error("postscaler did not wrap");

  a_count_write_scalers: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_count) |=> pre_cnt_q == 6'h00 && post_cnt_q == 4'h0)
    else $error("count write kept scalers");

  a_count_no_tick: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!pre_tick && !(wr_take && wr_count)) |=> $stable(timer_count_q))
    else $error("count moved without tick");

  // Stopped and sleeping timer
  a_stop_holds_scalers: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!running && !scaler_clr) |=> $stable(pre_cnt_q) && $stable(post_cnt_q))
    else $error("scalers moved while stopped");

  a_stop_no_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !running |=> !period_match_pulse_out)
    else $error("match pulse while stopped");

  a_sleep_no_instr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    sleep_q |-> !instr_tick)
    else $error("instruction tick in sleep");

  a_sleep_no_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    sleep_q |=> !period_match_pulse_out)
    else $error("match pulse in sleep");

  a_period_sleep_stable: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (sleep_q && !(wr_take && wr_period)) |=> $stable(period_value_q))
    else $error("period moved in sleep");

  a_sleep_holds_scalers: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (sleep_q && !scaler_clr) |=> $stable(pre_cnt_q) && $stable(post_cnt_q))
    else $error("scalers moved in sleep");

  // Match output, flag and interrupt
  a_pulse_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    period_match_pulse_out |=> !period_match_pulse_out)
    else $error("match pulse wider than one cycle");

  a_flag_source: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(match_flag_q) |-> $past(flag_set))
    else $error("flag set without postscaler wrap");

  a_flag_set_wins: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    flag_set |=> match_flag_q)
    else $error("set lost to clear");

  a_flag_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_take && wr_clear && wdata_lo[MATCH_BIT] && !flag_set) |=> !match_flag_q)
    else $error("clear write ignored");

  a_irq_follows: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (match_flag_q && match_irq_enable_q) |=> irq_out)
    else $error("enabled flag gave no interrupt");

  a_irq_low_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !match_irq_enable_q |=> !irq_out)
    else $error("interrupt while disabled");
endmodule

// ==== test_period_timer_prescale_postscale.sv ====
// Self-checking testbench for the period timer, driven over APB
`timescale 1ns/1ps
module test_period_timer_prescale_postscale;
  import ptm_pkg::*;
  logic         clk_sys_in;
  logic         rst_n_in;
  ptm_apb_req_t req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         match_pulse;
  logic         irq;
  int           fail_count;
  int           samples_checked;
  logic [31:0]  rdv;
  logic         errv;
  int           gapv;

  ptm_timer u_ptm_timer (
    .clk_sys_in             (clk_sys_in),
    .rst_n_in               (rst_n_in),
    .apb_req_in             (req),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .period_match_pulse_out (match_pulse),
    .irq_out                (irq)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // Request is held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rdv = prdata;
    errv = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // Bounded wait for the next match pulse
  task automatic wpulse();
    int n;
    n = 0;
    while (match_pulse !== 1'b1 && n < 4000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 4000) begin
      fail_count++;
      summarize();
    end
    @(posedge clk_sys_in);
  endtask

  task automatic gap(output int c);
    int n;
    wpulse();
    c = 1;
    n = 0;
    while (match_pulse !== 1'b1 && n < 4000) begin
      @(posedge clk_sys_in);
      c++;
      n++;
    end
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] o, input logic r, input logic [1:0] k);
    return {24'h0, 1'b0, o, r, k};
  endfunction

  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fail_count++;
    summarize();
  end

  initial begin
    rst_n_in = 1'b0;
    req = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rc("count reset", ADDR_COUNT, 32'h00);
    rc("period reset", ADDR_PERIOD, 32'hff);
    rc("control reset", ADDR_CONTROL, 32'h00);
    rc("status reset", ADDR_STATUS, 32'h00);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    wr(ADDR_CONTROL, 32'hff);
    rc("control bit7", ADDR_CONTROL, 32'h7f);
    wr(ADDR_CONTROL, 32'h00);
    wr(ADDR_COUNT, 32'h55);
    rc("count rw", ADDR_COUNT, 32'h55);
    wr(ADDR_PERIOD, 32'h02);
    rc("period rw", ADDR_PERIOD, 32'h02);
    apb(1'b1, 12'h01c, 32'h1);
    chk("unmapped err", 32'h1, {31'h0, errv});
    rc("unmapped read", 12'h01c, 32'h0);
    $display("test access done");
    // Period 2 gives three ticks per match; a tick is four clocks times the prescale
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL, ctl(4'h0, 1'b1, 2'(i)));
      gap(gapv);
      chk("match gap", 32'd12 << (2 * i), 32'(gapv));
    end
    $display("test prescale done");
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CLEAR, 32'h1);
    wr(ADDR_ENABLE, 32'h0);
    wr(ADDR_PERIOD, 32'h20);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CONTROL, ctl(4'h2, 1'b1, 2'h0));
    wpulse();
    wpulse();
    rc("flag after two", ADDR_STATUS, 32'h0);
    wpulse();
    idle(2);
    rc("flag after three", ADDR_STATUS, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_ENABLE, 32'h1);
    idle(2);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(ADDR_CONTROL, 32'h0);
    idle(300);
    rc("flag sticky", ADDR_STATUS, 32'h1);
    wr(ADDR_CLEAR, 32'h1);
    idle(2);
    rc("flag cleared", ADDR_STATUS, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    wr(ADDR_COUNT, 32'h10);
    idle(200);
    rc("count stopped", ADDR_COUNT, 32'h10);
    wr(ADDR_CONTROL, ctl(4'h5, 1'b0, 2'h1));
    rc("count after control", ADDR_COUNT, 32'h10);
    wr(ADDR_SLEEP, 32'h1);
    wr(ADDR_CONTROL, ctl(4'h0, 1'b1, 2'h0));
    idle(400);
    rc("count in sleep", ADDR_COUNT, 32'h10);
    rc("period in sleep", ADDR_PERIOD, 32'h20);
    wr(ADDR_SLEEP, 32'h0);
    $display("test hold done");
    wr(ADDR_COUNT, 32'h33);
    wr(ADDR_PERIOD, 32'h44);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    idle(4);
    rst_n_in <= 1'b1;
    rc("count after reset", ADDR_COUNT, 32'h00);
    rc("period after reset", ADDR_PERIOD, 32'hff);
    rc("control after reset", ADDR_CONTROL, 32'h00);
    $display("test second reset done");
    summarize();
  end
endmodule
